//--- shreg_pkg.sv
package shreg_pkg;

  // ****************************************************************
  // sizes and reset values
  // ****************************************************************
  localparam int REG_WIDTH = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] PAR_OUT_RESET = 4'h0;
  localparam logic SYNC_RESET = 1'h0;

  // ****************************************************************
  // operation selected by the mode pair {mode_sel_hi, mode_sel_lo}
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_HOLD = 2'h0,
    MODE_SHIFT_UP = 2'h1,
    MODE_LOAD = 2'h3,
    MODE_SHIFT_DOWN = 2'h2
  } mode_type;

endpackage

//--- pin_sync_if.sv
`timescale 1ns/10ps

// ****************************************************************
// synchronised pin levels plus the shift clock rising-edge strobe
// ****************************************************************
interface pin_sync_if #(
  parameter int WIDTH = 4
);
  logic clear_n;
  logic mode_sel_hi;
  logic mode_sel_lo;
  logic serial_in_left;
  logic serial_in_right;
  logic [WIDTH-1:0] par_in;
  logic shift_rise;

  modport source (
    output clear_n,
    output mode_sel_hi,
    output mode_sel_lo,
    output serial_in_left,
    output serial_in_right,
    output par_in,
    output shift_rise
  );

  modport sink (
    input clear_n,
    input mode_sel_hi,
    input mode_sel_lo,
    input serial_in_left,
    input serial_in_right,
    input par_in,
    input shift_rise
  );
endinterface

//--- pin_sync.sv
`timescale 1ns/10ps

module pin_sync
  import shreg_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic clear_n,
  input wire logic mode_sel_hi,
  input wire logic mode_sel_lo,
  input wire logic serial_in_left,
  input wire logic serial_in_right,
  input wire logic [WIDTH-1:0] par_in,
  pin_sync_if.source syn
);

  // ****************************************************************
  // two-stage synchronisers, one per pin bit
  // ****************************************************************
  localparam int N = WIDTH + 6;

  logic [N-1:0] raw;
  logic [N-1:0] stage1;
  logic [N-1:0] stage2;
  logic [N-1:0] next_stage1;
  logic [N-1:0] next_stage2;
  logic clk_prev;
  logic next_clk_prev;

  // all pins travel the same depth so data lines up with the clock edge
  assign raw = {shift_clk, clear_n, mode_sel_hi, mode_sel_lo,
                serial_in_left, serial_in_right, par_in};

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      // stage1 feeds only stage2
      always_comb
      begin
        next_stage1[i] = rst_n ? raw[i] : SYNC_RESET;
        next_stage2[i] = rst_n ? stage1[i] : SYNC_RESET;
      end

      always_ff @(posedge clock)
      begin
        stage1[i] <= next_stage1[i];
        stage2[i] <= next_stage2[i];
      end
    end
  endgenerate

  // ****************************************************************
  // edge detector works on the settled second stage only
  // ****************************************************************
  always_comb
  begin
    next_clk_prev = rst_n ? stage2[N-1] : SYNC_RESET;
  end

  always_ff @(posedge clock)
  begin
    clk_prev <= next_clk_prev;
  end

  assign syn.shift_rise = stage2[N-1] & ~clk_prev;
  assign syn.clear_n = stage2[N-2];
  assign syn.mode_sel_hi = stage2[N-3];
  assign syn.mode_sel_lo = stage2[N-4];
  assign syn.serial_in_left = stage2[N-5];
  assign syn.serial_in_right = stage2[N-6];
  assign syn.par_in = stage2[WIDTH-1:0];

endmodule

//--- universal_shift_register_4b.sv
`timescale 1ns/10ps

// How it works
// - four stored bits drive par_out continuously
// - mode and data inputs take effect only on a rising shift_clk edge
// - clear_n low forces all bits to zero and blocks clock edges
// - mode pair both low: hold contents, ignore data inputs
// - mode pair both high: load par_in bit for bit
// - lo high, hi low: bit 0 takes serial_in_right, bits move up
// - hi high, lo low: bit 3 takes serial_in_left, bits move down
// - all bits update together from values just before the edge
// - unused serial and parallel inputs are ignored, allowing cascades
module universal_shift_register_4b
  import shreg_pkg::*;
#(
  parameter int WIDTH = REG_WIDTH
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic shift_clk,
  input wire logic clear_n,
  input wire logic mode_sel_hi,
  input wire logic mode_sel_lo,
  input wire logic serial_in_left,
  input wire logic serial_in_right,
  input wire logic [WIDTH-1:0] par_in,
  output logic [WIDTH-1:0] par_out
);

  // ****************************************************************
  // pin synchronisation
  // ****************************************************************
  pin_sync_if #(.WIDTH(WIDTH)) syn ();

  // every pin is asynchronous to clock, so all of them go through here
  pin_sync #(.WIDTH(WIDTH)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .shift_clk(shift_clk),
    .clear_n(clear_n),
    .mode_sel_hi(mode_sel_hi),
    .mode_sel_lo(mode_sel_lo),
    .serial_in_left(serial_in_left),
    .serial_in_right(serial_in_right),
    .par_in(par_in),
    .syn(syn.source)
  );

  // ****************************************************************
  // mode decode
  // ****************************************************************
  mode_type mode;

  assign mode = mode_type'({syn.mode_sel_hi, syn.mode_sel_lo});

  // ****************************************************************
  // register update
  // ****************************************************************
  logic [WIDTH-1:0] next_par_out;

  // one next value from pre-edge state; no bit sees another's new value
  always_comb
  begin
    next_par_out = par_out;
    if (!rst_n)
    begin
      next_par_out = PAR_OUT_RESET[WIDTH-1:0];
    end
    else if (!syn.clear_n)
    begin
      // clear wins over any edge; limitation: seen two clocks late
      next_par_out = PAR_OUT_RESET[WIDTH-1:0];
    end
    else if (syn.shift_rise)
    begin
      case (mode)
        MODE_HOLD:
        begin
          next_par_out = par_out;
        end
        MODE_SHIFT_UP:
        begin
          // par_in and serial_in_left unused here
          next_par_out = {par_out[WIDTH-2:0], syn.serial_in_right};
        end
        MODE_SHIFT_DOWN:
        begin
          next_par_out = {syn.serial_in_left, par_out[WIDTH-1:1]};
        end
        MODE_LOAD:
        begin
          next_par_out = syn.par_in;
        end
        default:
        begin
          next_par_out = par_out;
        end
      endcase
    end
  end

  // the stored value is the output itself
  always_ff @(posedge clock)
  begin
    par_out <= next_par_out;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking

  default disable iff (!rst_n);

  // helper: has reset been off for three clocks, so $past holds real values
  logic [2:0] live;
  logic [2:0] next_live;

  always_comb
  begin
    next_live = rst_n ? {live[1:0], 1'h1} : 3'h0;
  end

  always_ff @(posedge clock)
  begin
    live <= next_live;
  end

  AST_CLEAR_ZERO: assert property (
    !syn.clear_n |=> par_out == '0
  ) else $error("register not zero after clear");

  AST_CLEAR_PIN: assert property (
    (!clear_n ##1 !clear_n ##1 !clear_n) |=> par_out == '0
  ) else $error("clear pin held low did not zero the register");

  AST_NO_EDGE_STABLE: assert property (
    (syn.clear_n && !syn.shift_rise) |=> $stable(par_out)
  ) else $error("register changed without a shift clock edge");

  AST_EDGE_FROM_PIN: assert property (
    (syn.shift_rise && live[2]) |-> ($past(shift_clk, 2) && !$past(shift_clk, 3))
  ) else $error("edge strobe without a pin rising edge");

  AST_HOLD: assert property (
    (syn.clear_n && syn.shift_rise && mode == MODE_HOLD) |=> $stable(par_out)
  ) else $error("hold mode changed the register");

  AST_LOAD: assert property (
    (syn.clear_n && syn.shift_rise && mode == MODE_LOAD) |=> par_out == $past(syn.par_in)
  ) else $error("parallel load mismatch");

  AST_SHIFT_UP: assert property (
    (syn.clear_n && syn.shift_rise && mode == MODE_SHIFT_UP)
      |=> par_out == {$past(par_out[WIDTH-2:0]), $past(syn.serial_in_right)}
  ) else $error("shift toward bit 3 mismatch");

  AST_SHIFT_DOWN: assert property (
    (syn.clear_n && syn.shift_rise && mode == MODE_SHIFT_DOWN)
      |=> par_out == {$past(syn.serial_in_left), $past(par_out[WIDTH-1:1])}
  ) else $error("shift toward bit 0 mismatch");

  // ****************************************************************
  // pin-level checks
  // ****************************************************************
  // a pin edge sampled at clock k shows on par_out from k+3 on;
  // these catch a synchroniser that skews data against the edge

  AST_PIN_LOAD: assert property (
    (live[2] && clear_n && mode_sel_hi && mode_sel_lo && shift_clk && !$past(shift_clk))
      |-> ##3 par_out == $past(par_in, 3)
  ) else $error("pin level load did not arrive three clocks later");

  AST_SHIFT_UP_LSB: assert property (
    (live[2] && clear_n && !mode_sel_hi && mode_sel_lo && shift_clk && !$past(shift_clk))
      |-> ##3 par_out[0] == $past(serial_in_right, 3)
  ) else $error("serial entry lost in shift toward bit 3");

  AST_SHIFT_DOWN_MSB: assert property (
    (live[2] && clear_n && mode_sel_hi && !mode_sel_lo && shift_clk && !$past(shift_clk))
      |-> ##3 par_out[WIDTH-1] == $past(serial_in_left, 3)
  ) else $error("serial entry lost in shift toward bit 0");

  AST_PIN_HOLD: assert property (
    (live[2] && clear_n && !mode_sel_hi && !mode_sel_lo && shift_clk && !$past(shift_clk))
      |-> ##3 $stable(par_out)
  ) else $error("pin level hold changed the register");

  AST_PIN_SHIFT_UP_BODY: assert property (
    (live[2] && clear_n && !mode_sel_hi && mode_sel_lo && shift_clk && !$past(shift_clk))
      |-> ##3 par_out[WIDTH-1:1] == $past(par_out[WIDTH-2:0])
  ) else $error("upper bits did not take their lower neighbours");

  AST_PIN_SHIFT_DOWN_BODY: assert property (
    (live[2] && clear_n && mode_sel_hi && !mode_sel_lo && shift_clk && !$past(shift_clk))
      |-> ##3 par_out[WIDTH-2:0] == $past(par_out[WIDTH-1:1])
  ) else $error("lower bits did not take their upper neighbours");

  AST_PIN_CLEAR_EDGE: assert property (
    (live[2] && !clear_n && shift_clk && !$past(shift_clk)) |-> ##3 par_out == '0
  ) else $error("edge taken while the clear pin was low");

  COV_LOAD: cover property (
    syn.clear_n && syn.shift_rise && mode == MODE_LOAD
  );

  COV_SHIFT_UP: cover property (
    syn.clear_n && syn.shift_rise && mode == MODE_SHIFT_UP
  );

  COV_SHIFT_DOWN: cover property (
    syn.clear_n && syn.shift_rise && mode == MODE_SHIFT_DOWN
  );

  COV_CLEAR_ON_EDGE: cover property (
    !syn.clear_n && syn.shift_rise
  );

  COV_HOLD: cover property (
    syn.clear_n && syn.shift_rise && mode == MODE_HOLD
  );

endmodule

//--- shreg_driver.sv
`timescale 1ns/10ps

// ********
// board logic driving the register pins
// ********
module shreg_driver
  import shreg_pkg::*;
(
  input wire logic clock,
  output logic shift_clk,
  output logic clear_n,
  output logic mode_sel_hi,
  output logic mode_sel_lo,
  output logic serial_in_left,
  output logic serial_in_right,
  output logic [3:0] par_in
);
  // shift clock parked low so reset release shows no false edge
  initial
  begin
    shift_clk = 1'h0;
    clear_n = 1'h1;
    {mode_sel_hi, mode_sel_lo} = MODE_HOLD;
    {serial_in_left, serial_in_right, par_in} = 6'h00;
  end

  // step n clock edges, landing just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // data settles before the edge, then flips so a late sample shows up
  task automatic op(input mode_type m, input logic [3:0] d, input logic sl,
                    input logic sr, input logic pulse);
    {mode_sel_hi, mode_sel_lo} = m;
    {serial_in_left, serial_in_right, par_in} = {sl, sr, d};
    tick(2);
    shift_clk = pulse;
    tick(2);
    {serial_in_left, serial_in_right, par_in} = ~{sl, sr, d};
    tick(2);
    shift_clk = 1'h0;
    tick(2);
  endtask

  // clear low across a load edge; released well away from any edge
  task automatic clear_over_edge();
    {mode_sel_hi, mode_sel_lo} = MODE_LOAD;
    par_in = 4'hF;
    clear_n = 1'h0;
    tick(2);
    shift_clk = 1'h1;
    tick(2);
    shift_clk = 1'h0;
    tick(3);
    clear_n = 1'h1;
    tick(3);
  endtask
endmodule

//--- universal_shift_register_4b_tb.sv
`timescale 1ns/10ps

module universal_shift_register_4b_tb;
  import shreg_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic shift_clk;
  logic clear_n;
  logic mode_sel_hi;
  logic mode_sel_lo;
  logic serial_in_left;
  logic serial_in_right;
  logic [3:0] par_in;
  logic [3:0] par_out;
  logic [3:0] model = 4'h0;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;

  // ********
  // clock, design and pin driver
  // ********
  always #25 clock = ~clock;

  universal_shift_register_4b u_universal_shift_register_4b (
    .clock(clock), .rst_n(rst_n), .shift_clk(shift_clk), .clear_n(clear_n),
    .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo), .serial_in_left(serial_in_left),
    .serial_in_right(serial_in_right), .par_in(par_in), .par_out(par_out));

  shreg_driver u_shreg_driver (
    .clock(clock), .shift_clk(shift_clk), .clear_n(clear_n),
    .mode_sel_hi(mode_sel_hi), .mode_sel_lo(mode_sel_lo), .serial_in_left(serial_in_left),
    .serial_in_right(serial_in_right), .par_in(par_in));

  // ********
  // checking helpers
  // ********
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: par_out %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // one clocked operation; expected value kept independently here
  task automatic step(input mode_type m, input logic [3:0] d, input logic sl, input logic sr);
    u_shreg_driver.op(m, d, sl, sr, 1'h1);
    case (m)
      MODE_SHIFT_UP: model = {model[2:0], sr};
      MODE_SHIFT_DOWN: model = {sl, model[3:1]};
      MODE_LOAD: model = d;
      default: model = model;
    endcase
  endtask

  // ********
  // scenarios
  // ********
  // every mode once; unused serial and parallel inputs set to mislead
  task automatic test_modes();
    step(MODE_LOAD, 4'hA, 1'h1, 1'h1);
    check(par_out, model);
    step(MODE_SHIFT_UP, 4'hC, 1'h0, 1'h1);
    check(par_out, model);
    step(MODE_SHIFT_DOWN, 4'h0, 1'h1, 1'h0);
    check(par_out, model);
    step(MODE_HOLD, 4'hF, 1'h1, 1'h1);
    check(par_out, model);
  endtask

  // a full word shifted out each way exposes any ripple between bits
  task automatic test_walk();
    step(MODE_LOAD, 4'hF, 1'h0, 1'h0);
    repeat (4)
    begin
      step(MODE_SHIFT_UP, 4'hF, 1'h1, 1'h0);
      check(par_out, model);
    end
    repeat (4)
    begin
      step(MODE_SHIFT_DOWN, 4'h0, 1'h1, 1'h0);
      check(par_out, model);
    end
  endtask

  // pins move with no shift clock edge: nothing may change
  task automatic test_no_edge();
    u_shreg_driver.op(MODE_LOAD, 4'h3, 1'h0, 1'h0, 1'h0);
    check(par_out, model);
  endtask

  // clear wins over a load edge, then normal work resumes
  task automatic test_clear();
    step(MODE_LOAD, 4'h5, 1'h0, 1'h0);
    u_shreg_driver.clear_over_edge();
    model = 4'h0;
    check(par_out, model);
    step(MODE_SHIFT_UP, 4'h0, 1'h0, 1'h1);
    check(par_out, model);
  endtask

  // mid-run reset: register returns to zero, work resumes with no false edge
  task automatic test_reset();
    step(MODE_LOAD, 4'h9, 1'h0, 1'h0);
    check(par_out, model);
    rst_n = 1'h0;
    u_shreg_driver.tick(3);
    model = PAR_OUT_RESET;
    check(par_out, model);
    rst_n = 1'h1;
    u_shreg_driver.tick(1);
    check(par_out, model);
    step(MODE_SHIFT_DOWN, 4'h0, 1'h1, 1'h0);
    check(par_out, model);
  endtask

  // hang guard: far beyond the length of the whole sequence
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      fails++;
      summarize();
    end
  end

  initial
  begin
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'h1;
    @(posedge clock);
    #1;
    check(par_out, PAR_OUT_RESET);
    test_modes();
    test_walk();
    test_no_edge();
    test_clear();
    test_reset();
    summarize();
  end
endmodule
